// File: rtl/fthys_crit_track.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// one channel's critical override latch
// ***************************************************************
module fthys_crit_track
   import fthys_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] temp, // measured code
   input wire logic [7:0] limit, // critical limit code
   input wire logic [3:0] hyst, // release hysteresis, degrees
   output logic active // override held for this channel
);

   // entry on strictly above, release on strictly below limit-hyst;
   // entry is tested first so a rising edge is never lost
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         active <= 1'b0;
      end
      else if (temp > limit)
      begin
         active <= 1'b1;
      end
      else if (below_hyst(temp, limit, hyst))
      begin
         active <= 1'b0;
      end
   end

endmodule // fthys_crit_track
`default_nettype wire

// File: rtl/fthys_pkg.sv
// ***************************************************************
// constants shared by the thermal override block
// ***************************************************************
package fthys_pkg;

   // ********
   // register indices; byte address is four times the index
   // ********
   localparam logic [7:0] IDX_MAX_DUTY_1 = 8'h38; // fan 1 loop ceiling
   localparam logic [7:0] IDX_MAX_DUTY_2 = 8'h39; // fan 2 loop ceiling
   localparam logic [7:0] IDX_MAX_DUTY_3 = 8'h3A; // fan 3 loop ceiling
   localparam logic [7:0] IDX_KEEP_CTRL = 8'h62; // keep-spinning bits
   localparam logic [7:0] IDX_CRIT_R1 = 8'h6A; // remote 1 critical limit
   localparam logic [7:0] IDX_CRIT_LOC = 8'h6B; // local critical limit
   localparam logic [7:0] IDX_CRIT_R2 = 8'h6C; // remote 2 critical limit
   localparam logic [7:0] IDX_HYST_A = 8'h6D; // remote1_local_hysteresis
   localparam logic [7:0] IDX_HYST_B = 8'h6E; // remote 2 hyst
   localparam logic [7:0] IDX_SRC_SEL = 8'h7C; // fan source channel
   localparam logic [7:0] IDX_STATUS = 8'h7D; // live state, read only

   // ********
   // byte addresses on the 12-bit bus
   // ********
   localparam logic [11:0] ADDR_MAX_DUTY_1 = {2'b00, IDX_MAX_DUTY_1, 2'b00};
   localparam logic [11:0] ADDR_MAX_DUTY_2 = {2'b00, IDX_MAX_DUTY_2, 2'b00};
   localparam logic [11:0] ADDR_MAX_DUTY_3 = {2'b00, IDX_MAX_DUTY_3, 2'b00};
   localparam logic [11:0] ADDR_KEEP_CTRL = {2'b00, IDX_KEEP_CTRL, 2'b00};
   localparam logic [11:0] ADDR_CRIT_R1 = {2'b00, IDX_CRIT_R1, 2'b00};
   localparam logic [11:0] ADDR_CRIT_LOC = {2'b00, IDX_CRIT_LOC, 2'b00};
   localparam logic [11:0] ADDR_CRIT_R2 = {2'b00, IDX_CRIT_R2, 2'b00};
   localparam logic [11:0] ADDR_HYST_A = {2'b00, IDX_HYST_A, 2'b00};
   localparam logic [11:0] ADDR_HYST_B = {2'b00, IDX_HYST_B, 2'b00};
   localparam logic [11:0] ADDR_SRC_SEL = {2'b00, IDX_SRC_SEL, 2'b00};
   localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

   // ********
   // field positions
   // ********
   localparam int KEEP_FAN1_BIT = 5; // fan 1 keep spinning
   localparam int KEEP_FAN2_BIT = 6; // fan 2 keep spinning
   localparam int KEEP_FAN3_BIT = 7; // fan 3 keep spinning
   localparam int HYST_HI_LSB = 4; // upper nibble field
   localparam int HYST_LO_LSB = 0; // lower nibble field
   localparam int STAT_OVR_LSB = 0; // per-channel override, 3 bits
   localparam int STAT_RUN_LSB = 3; // per-fan running, 3 bits
   localparam int STAT_ANY_BIT = 6; // forced full duty

   // ********
   // reset values
   // ********
   localparam logic [7:0] RST_CRIT = 8'hA4; // 100 degrees
   localparam logic [7:0] RST_HYST_A = 8'h44; // 4 and 4 degrees
   localparam logic [7:0] RST_HYST_B = 8'h40; // 4 degrees, low reserved
   localparam logic [7:0] RST_MAX_DUTY = 8'hFF; // no ceiling
   localparam logic [2:0] RST_KEEP = 3'h0; // fans stop when cold
   localparam logic [5:0] RST_SRC_SEL = 6'h24; // fan n on channel n

   // ********
   // duty codes
   // ********
   localparam logic [7:0] DUTY_FULL = 8'hFF; // 100 percent
   localparam logic [7:0] DUTY_OFF = 8'h00; // 0 percent

   // true when temp is strictly below limit minus hysteresis;
   // widened so a small limit never wraps below zero
   function automatic logic below_hyst(input logic [7:0] temp,
                                       input logic [7:0] limit,
                                       input logic [3:0] hyst);
      logic [8:0] sum;
      sum = {1'b0, temp} + {5'h00, hyst};
      below_hyst = sum < {1'b0, limit};
   endfunction

endpackage

// File: rtl/fthys_top.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fthys_top
   import fthys_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // temperature channels, same clock as this block
   input wire logic [7:0] tempRemote1,
   input wire logic [7:0] tempLocal,
   input wire logic [7:0] tempRemote2,
   // per-fan automatic loop results
   input wire logic [7:0] loopDuty1,
   input wire logic [7:0] loopDuty2,
   input wire logic [7:0] loopDuty3,
   input wire logic [7:0] floorDuty1,
   input wire logic [7:0] floorDuty2,
   input wire logic [7:0] floorDuty3,
   input wire logic [7:0] startTemp1,
   input wire logic [7:0] startTemp2,
   input wire logic [7:0] startTemp3,
   // fan drive duty and override indication
   output logic [7:0] fanDriveOut1,
   output logic [7:0] fanDriveOut2,
   output logic [7:0] fanDriveOut3,
   output logic overtempPin_n
);

   // ********
   // storage
   // ********
   logic [7:0] critLimit [0:2]; // per-channel critical limits
   logic [7:0] maxDuty [0:2]; // per-fan loop ceilings
   logic [7:0] hystA; // remote 1 high nibble, local low nibble
   logic [3:0] hystB; // remote 2 hysteresis
   logic [2:0] keepSpin; // fan3, fan2, fan1 keep bits
   logic [5:0] srcSel; // two bits per fan, source channel
   logic [2:0] chanOvr; // per-channel override state
   logic anyOvr; // any channel holding override
   logic [2:0] fanOn; // per-fan running state
   logic [7:0] fanDuty [0:2]; // registered fan drive values
   logic [7:0] next_fanDuty [0:2]; // duty to load next edge

   // ********
   // per-channel views
   // ********
   logic [7:0] chanTemp [0:2]; // channel temperature codes
   logic [3:0] chanHyst [0:2]; // channel hysteresis values
   logic [7:0] loopDuty [0:2]; // fan loop results
   logic [7:0] floorDuty [0:2]; // fan floor duties
   logic [7:0] startTemp [0:2]; // fan start temperatures
   logic [7:0] fanTemp [0:2]; // temperature steering each fan
   logic [3:0] fanHyst [0:2]; // hysteresis steering each fan

   // ********
   // bus decode
   // ********
   logic setupPhase; // first cycle of a transfer
   logic wrStrobe; // completing write
   logic addrHit; // address lands on a register
   logic [7:0] rdValue; // read value for current address
   logic [31:0] next_prdata; // word captured in setup

   // gather the separate ports into arrays for indexing
   always_comb
   begin
      chanTemp[0] = tempRemote1;
      chanTemp[1] = tempLocal;
      chanTemp[2] = tempRemote2;
      // one nibble per channel, shared by both thresholds
      chanHyst[0] = hystA[HYST_HI_LSB +: 4];
      chanHyst[1] = hystA[HYST_LO_LSB +: 4];
      chanHyst[2] = hystB;
      loopDuty[0] = loopDuty1;
      loopDuty[1] = loopDuty2;
      loopDuty[2] = loopDuty3;
      floorDuty[0] = floorDuty1;
      floorDuty[1] = floorDuty2;
      floorDuty[2] = floorDuty3;
      startTemp[0] = startTemp1;
      startTemp[1] = startTemp2;
      startTemp[2] = startTemp3;
   end

   // steer each fan from its selected channel; code 3 maps to
   // remote 2 so that no selection leaves a fan unsteered
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         case (srcSel[2*i +: 2])
            2'd0:
            begin
               fanTemp[i] = chanTemp[0];
               fanHyst[i] = chanHyst[0];
            end
            2'd1:
            begin
               fanTemp[i] = chanTemp[1];
               fanHyst[i] = chanHyst[1];
            end
            default:
            begin
               fanTemp[i] = chanTemp[2];
               fanHyst[i] = chanHyst[2];
            end
         endcase
      end
   end

   // ********
   // apb slave
   // ********

   // zero wait states: every access completes in one access cycle
   assign pready = 1'b1;
   assign setupPhase = psel && !penable;
   assign wrStrobe = psel && penable && pwrite && addrHit;

   // address match and read mux, held stable by the master
   always_comb
   begin
      addrHit = 1'b1;
      rdValue = 8'h00;
      if (paddr == ADDR_MAX_DUTY_1)
      begin
         rdValue = maxDuty[0];
      end
      else if (paddr == ADDR_MAX_DUTY_2)
      begin
         rdValue = maxDuty[1];
      end
      else if (paddr == ADDR_MAX_DUTY_3)
      begin
         rdValue = maxDuty[2];
      end
      else if (paddr == ADDR_KEEP_CTRL)
      begin
         // other bits belong to logic outside this block
         rdValue = {keepSpin, 5'h00};
      end
      else if (paddr == ADDR_CRIT_R1)
      begin
         rdValue = critLimit[0];
      end
      else if (paddr == ADDR_CRIT_LOC)
      begin
         rdValue = critLimit[1];
      end
      else if (paddr == ADDR_CRIT_R2)
      begin
         rdValue = critLimit[2];
      end
      else if (paddr == ADDR_HYST_A)
      begin
         rdValue = hystA;
      end
      else if (paddr == ADDR_HYST_B)
      begin
         // low nibble reserved, reads zero
         rdValue = {hystB, 4'h0};
      end
      else if (paddr == ADDR_SRC_SEL)
      begin
         rdValue = {2'b00, srcSel};
      end
      else if (paddr == ADDR_STATUS)
      begin
         rdValue = {1'b0, anyOvr, fanOn, chanOvr};
      end
      else
      begin
         // unmapped: flagged as error, reads zero
         addrHit = 1'b0;
      end
   end

   // unmapped access answered with an error in the access cycle
   assign pslverr = psel && penable && !addrHit;
   assign next_prdata = {24'h000000, rdValue};

   // read data loaded in setup so it comes from a flop at access
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata <= 32'h00000000;
      end
      else if (setupPhase && !pwrite)
      begin
         prdata <= next_prdata;
      end
   end

   // critical limits, consecutive indices, 100 degree reset
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         critLimit[0] <= RST_CRIT;
         critLimit[1] <= RST_CRIT;
         critLimit[2] <= RST_CRIT;
      end
      else if (wrStrobe)
      begin
         if (paddr == ADDR_CRIT_R1)
         begin
            critLimit[0] <= pwdata[7:0];
         end
         else if (paddr == ADDR_CRIT_LOC)
         begin
            critLimit[1] <= pwdata[7:0];
         end
         else if (paddr == ADDR_CRIT_R2)
         begin
            critLimit[2] <= pwdata[7:0];
         end
      end
   end

   // hysteresis registers; a zero is stored as written, which
   // simply removes the dead band, so software must avoid it
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hystA <= RST_HYST_A;
         hystB <= RST_HYST_B[HYST_HI_LSB +: 4];
      end
      else if (wrStrobe)
      begin
         if (paddr == ADDR_HYST_A)
         begin
            hystA <= pwdata[7:0];
         end
         else if (paddr == ADDR_HYST_B)
         begin
            hystB <= pwdata[HYST_HI_LSB +: 4];
         end
      end
   end

   // loop ceilings, one byte per output
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         maxDuty[0] <= RST_MAX_DUTY;
         maxDuty[1] <= RST_MAX_DUTY;
         maxDuty[2] <= RST_MAX_DUTY;
      end
      else if (wrStrobe)
      begin
         if (paddr == ADDR_MAX_DUTY_1)
         begin
            maxDuty[0] <= pwdata[7:0];
         end
         else if (paddr == ADDR_MAX_DUTY_2)
         begin
            maxDuty[1] <= pwdata[7:0];
         end
         else if (paddr == ADDR_MAX_DUTY_3)
         begin
            maxDuty[2] <= pwdata[7:0];
         end
      end
   end

   // keep-spinning bits and fan source selection
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         keepSpin <= RST_KEEP;
         srcSel <= RST_SRC_SEL;
      end
      else if (wrStrobe)
      begin
         if (paddr == ADDR_KEEP_CTRL)
         begin
            keepSpin <= pwdata[KEEP_FAN3_BIT:KEEP_FAN1_BIT];
         end
         else if (paddr == ADDR_SRC_SEL)
         begin
            srcSel <= pwdata[5:0];
         end
      end
   end

   // ********
   // critical override, one latch per channel
   // ********
   for (genvar c = 0; c < 3; c++)
   begin : g_chan
      fthys_crit_track u_track (
         .clk_sys(clk_sys),
         .reset_n(reset_n),
         .temp(chanTemp[c]),
         .limit(critLimit[c]),
         .hyst(chanHyst[c]),
         .active(chanOvr[c])
      );
   end

   // any held channel forces every fan; no enable gates it
   assign anyOvr = |chanOvr;

   // ********
   // fan on/off hysteresis
   // ********

   // on when strictly above start, off only once strictly below
   // start minus the same channel hysteresis used for override
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fanOn <= 3'b000;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            if (fanTemp[i] > startTemp[i])
            begin
               fanOn[i] <= 1'b1;
            end
            else if (below_hyst(fanTemp[i], startTemp[i], fanHyst[i]))
            begin
               fanOn[i] <= 1'b0;
            end
         end
      end
   end

   // ********
   // duty selection
   // ********

   // priority: override, then loop under its ceiling, then cold
   // behaviour; a kept fan tracks the start point directly, so
   // hysteresis cannot hold it on the loop path
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (anyOvr)
         begin
            // bypasses the ceiling on purpose
            next_fanDuty[i] = DUTY_FULL;
         end
         else if (keepSpin[i] ? (fanTemp[i] > startTemp[i]) : fanOn[i])
         begin
            if (loopDuty[i] > maxDuty[i])
            begin
               next_fanDuty[i] = maxDuty[i];
            end
            else
            begin
               next_fanDuty[i] = loopDuty[i];
            end
         end
         else if (keepSpin[i])
         begin
            next_fanDuty[i] = floorDuty[i];
         end
         else
         begin
            next_fanDuty[i] = DUTY_OFF;
         end
      end
   end

   // registered drive values, stopped fans at reset
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fanDuty[0] <= DUTY_OFF;
         fanDuty[1] <= DUTY_OFF;
         fanDuty[2] <= DUTY_OFF;
      end
      else
      begin
         fanDuty[0] <= next_fanDuty[0];
         fanDuty[1] <= next_fanDuty[1];
         fanDuty[2] <= next_fanDuty[2];
      end
   end

   // override indication, low while full duty is forced
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         overtempPin_n <= 1'b1;
      end
      else
      begin
         overtempPin_n <= !anyOvr;
      end
   end

   assign fanDriveOut1 = fanDuty[0];
   assign fanDriveOut2 = fanDuty[1];
   assign fanDriveOut3 = fanDuty[2];

endmodule // fthys_top
`default_nettype wire

// File: test/fan_thermal_override_hysteresis_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fan_thermal_override_hysteresis_tb_top
   import fthys_pkg::*;
;
   typedef struct {
      logic [7:0] t1, t2, t3, f1, f2, f3;
      logic pin;
   } fthys_row_t;
   logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] tempRemote1, tempLocal, tempRemote2;
   logic [7:0] loopDuty1, loopDuty2, loopDuty3, floorDuty1, floorDuty2;
   logic [7:0] floorDuty3, startTemp1, startTemp2, startTemp3;
   logic [7:0] fanDriveOut1, fanDriveOut2, fanDriveOut3;
   logic overtempPin_n;
   int fails, comparisons;
   // hyst: remote 1 is 3, local 5, remote 2 is 2; local limit 60
   fthys_row_t rows [13] = '{
      '{8'h40, 8'h40, 8'h40, 8'h00, 8'h00, 8'h40, 1'b1},
      '{8'h51, 8'h51, 8'h51, 8'h70, 8'h90, 8'hA0, 1'b1},
      '{8'h4E, 8'h4E, 8'h4E, 8'h70, 8'h90, 8'h40, 1'b1},
      '{8'h4C, 8'h4C, 8'h4C, 8'h00, 8'h90, 8'h40, 1'b1},
      '{8'h51, 8'h61, 8'h51, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{8'h51, 8'h5C, 8'h51, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{8'h51, 8'h5A, 8'h51, 8'h70, 8'h90, 8'hA0, 1'b1},
      '{8'h51, 8'h60, 8'h51, 8'h70, 8'h90, 8'hA0, 1'b1},
      '{8'hA5, 8'h51, 8'h51, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{8'hA1, 8'h51, 8'hA5, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{8'h51, 8'h51, 8'hA5, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{8'h51, 8'h51, 8'hA2, 8'hFF, 8'hFF, 8'hFF, 1'b0},
      '{8'h51, 8'h51, 8'hA1, 8'h70, 8'h90, 8'hA0, 1'b1}
   };
   fthys_top DUT (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tempRemote1, .tempLocal,
      .tempRemote2, .loopDuty1, .loopDuty2, .loopDuty3, .floorDuty1,
      .floorDuty2, .floorDuty3, .startTemp1, .startTemp2, .startTemp3,
      .fanDriveOut1, .fanDriveOut2, .fanDriveOut3, .overtempPin_n);
   fthys_far_model far (.clk_sys, .tempRemote1, .tempLocal, .tempRemote2,
      .loopDuty1, .loopDuty2, .loopDuty3, .floorDuty1, .floorDuty2,
      .floorDuty3, .startTemp1, .startTemp2, .startTemp3);
   // ********
   // shared tasks
   // ********
   task automatic results;
      $display("counts %0d comparisons %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one transfer, held until pready is seen at an edge
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [7:0] d, output logic [31:0] r, output logic e);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask
   task automatic rd(input string nm, input logic [11:0] a,
      input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 8'h00, r, e);
      chk(nm, {24'h0, x}, r);
   endtask
   // override needs two edges, a third lets everything land
   task automatic settle;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic fans(input logic [7:0] a, b, c, input logic p);
      chk("fan1", {24'h0, a}, {24'h0, fanDriveOut1});
      chk("fan2", {24'h0, b}, {24'h0, fanDriveOut2});
      chk("fan3", {24'h0, c}, {24'h0, fanDriveOut3});
      chk("pin", {31'h0, p}, {31'h0, overtempPin_n});
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // tests need under 400 cycles; 4000 ends a hang
   initial
   begin
      #200000;
      fails++;
      results();
   end
   // ********
   // main sequence
   // ********
   initial
   begin
      logic [31:0] r;
      logic e;
      reset_n = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd("critR1", ADDR_CRIT_R1, RST_CRIT);
      rd("critLoc", ADDR_CRIT_LOC, RST_CRIT);
      rd("critR2", ADDR_CRIT_R2, RST_CRIT);
      rd("hystA", ADDR_HYST_A, 8'h44);
      rd("hystB", ADDR_HYST_B, 8'h40);
      rd("keep", ADDR_KEEP_CTRL, 8'h00);
      apb(12'h000, 1'b0, 8'h00, r, e);
      chk("unmappedErr", 32'h1, {31'h0, e});
      wr(ADDR_MAX_DUTY_1, 8'h70);
      wr(ADDR_CRIT_LOC, 8'h60);
      wr(ADDR_HYST_A, 8'h35); // never zero
      wr(ADDR_HYST_B, 8'h2F); // never zero
      wr(ADDR_KEEP_CTRL, 8'h9F);
      rd("hystA", ADDR_HYST_A, 8'h35);
      rd("hystB", ADDR_HYST_B, 8'h20);
      rd("keep", ADDR_KEEP_CTRL, 8'h80);
      rd("critLoc", ADDR_CRIT_LOC, 8'h60);
      $display("test registers done");
      foreach (rows[i])
      begin
         far.setTemps(rows[i].t1, rows[i].t2, rows[i].t3);
         settle();
         fans(rows[i].f1, rows[i].f2, rows[i].f3, rows[i].pin);
      end
      $display("test table done");
      far.setTemps(8'h40, 8'h40, 8'h40);
      wr(ADDR_KEEP_CTRL, 8'hE0);
      settle();
      fans(8'h20, 8'h30, 8'h40, 1'b1);
      wr(ADDR_KEEP_CTRL, 8'h00);
      settle();
      fans(8'h00, 8'h00, 8'h00, 1'b1);
      $display("test keep done");
      // all fans steered from remote 1
      wr(ADDR_SRC_SEL, 8'h00);
      far.setTemps(8'h51, 8'h40, 8'h40);
      settle();
      fans(8'h70, 8'h90, 8'hA0, 1'b1);
      $display("test steering done");
      // a zero ceiling must not hold back the override
      wr(ADDR_MAX_DUTY_2, 8'h00);
      wr(ADDR_KEEP_CTRL, 8'hE0);
      far.setTemps(8'h40, 8'h65, 8'h40);
      settle();
      fans(8'hFF, 8'hFF, 8'hFF, 1'b0);
      rd("status", ADDR_STATUS, 8'h42);
      $display("test unmaskable done");
      // reset in mid override
      @(posedge clk_sys);
      reset_n <= 1'b0;
      #1;
      fans(8'h00, 8'h00, 8'h00, 1'b1);
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd("critLoc", ADDR_CRIT_LOC, RST_CRIT);
      rd("hystA", ADDR_HYST_A, 8'h44);
      $display("test reset done");
      results();
   end
endmodule // fan_thermal_override_hysteresis_tb_top
`default_nettype wire

// File: test/fthys_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// temperature channels and loop results
// ********
module fthys_far_model
(
   input wire logic clk_sys,
   output logic [7:0] tempRemote1,
   output logic [7:0] tempLocal,
   output logic [7:0] tempRemote2,
   output logic [7:0] loopDuty1,
   output logic [7:0] loopDuty2,
   output logic [7:0] loopDuty3,
   output logic [7:0] floorDuty1,
   output logic [7:0] floorDuty2,
   output logic [7:0] floorDuty3,
   output logic [7:0] startTemp1,
   output logic [7:0] startTemp2,
   output logic [7:0] startTemp3
);
   // cold start; loop values differ per fan to catch swaps
   initial
   begin
      {tempRemote1, tempLocal, tempRemote2} = {3{8'h40}};
      {loopDuty1, loopDuty2, loopDuty3} = {8'h80, 8'h90, 8'hA0};
      {floorDuty1, floorDuty2, floorDuty3} = {8'h20, 8'h30, 8'h40};
      {startTemp1, startTemp2, startTemp3} = {3{8'h50}};
   end
   // new readings land just after an edge
   task automatic setTemps(input logic [7:0] a, b, c);
      @(posedge clk_sys);
      {tempRemote1, tempLocal, tempRemote2} <= {a, b, c};
   endtask
endmodule // fthys_far_model
`default_nettype wire

// File: test/fthys_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fthys_top_chk
   import fthys_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] tempRemote1,
   input wire logic [7:0] tempLocal,
   input wire logic [7:0] tempRemote2,
   input wire logic [7:0] floorDuty1,
   input wire logic [7:0] startTemp1,
   input wire logic [7:0] fanDriveOut1,
   input wire logic [7:0] fanDriveOut2,
   input wire logic [7:0] fanDriveOut3,
   input wire logic overtempPin_n
);
   // ********
   // shadow of the limit registers
   // ********
   logic [7:0] lim0, lim1, lim2; // critical limits
   logic [7:0] hyA; // remote 1 high, local low
   logic [3:0] hyB; // remote 2
   logic keep1; // fan 1 keeps spinning
   logic [2:0] over, rel; // entry and release per channel
   logic cold1, warm1; // fan 1 below its start
   // stores at the very edge the design stores
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {lim0, lim1, lim2} <= {3{RST_CRIT}};
         hyA <= RST_HYST_A;
         hyB <= RST_HYST_B[7:4];
         keep1 <= 1'b0;
      end
      else if (psel && penable && pwrite)
      begin
         case (paddr)
            ADDR_CRIT_R1: lim0 <= pwdata[7:0];
            ADDR_CRIT_LOC: lim1 <= pwdata[7:0];
            ADDR_CRIT_R2: lim2 <= pwdata[7:0];
            ADDR_HYST_A: hyA <= pwdata[7:0];
            ADDR_HYST_B: hyB <= pwdata[7:4];
            ADDR_KEEP_CTRL: keep1 <= pwdata[KEEP_FAN1_BIT];
            default: ;
         endcase
      end
   end
   // sums widened so a low limit never wraps
   always_comb
   begin
      over = {tempRemote2 > lim2, tempLocal > lim1, tempRemote1 > lim0};
      rel[0] = {1'b0, tempRemote1} + 9'(hyA[7:4]) < {1'b0, lim0};
      rel[1] = {1'b0, tempLocal} + 9'(hyA[3:0]) < {1'b0, lim1};
      rel[2] = {1'b0, tempRemote2} + 9'(hyB) < {1'b0, lim2};
      cold1 = !keep1 && ({1'b0, tempRemote1} + 9'(hyA[7:4])
         < {1'b0, startTemp1});
      warm1 = keep1 && tempRemote1 <= startTemp1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // ********
   // override path
   // ********
   a_override_full:
   assert property (!overtempPin_n |-> fanDriveOut1 == DUTY_FULL
      && fanDriveOut2 == DUTY_FULL && fanDriveOut3 == DUTY_FULL)
      else $error("fan below full while override held");
   a_entry_two:
   assert property ((|over) |-> ##2 !overtempPin_n)
      else $error("override not raised two edges after entry");
   a_hold_band:
   assert property ((|over) ##1 (rel == 3'b000) |-> ##2 !overtempPin_n)
      else $error("override dropped inside the band");
   a_release_all:
   assert property ((&rel) |-> ##2 overtempPin_n)
      else $error("override held after every channel cooled");
   // ********
   // fan 1 below start
   // ********
   a_keep_floor:
   assert property (warm1 ##1 overtempPin_n
      |-> fanDriveOut1 == $past(floorDuty1))
      else $error("kept fan not at floor duty");
   a_cold_stop:
   assert property (cold1 [*2] ##1 overtempPin_n
      |-> fanDriveOut1 == DUTY_OFF)
      else $error("cold fan not stopped");
   // ********
   // register bus
   // ********
   a_zero_wait:
   assert property (psel && penable |-> pready)
      else $error("access stalled");
   a_unmapped_err:
   assert property (psel && penable && paddr == 12'h000
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_ok:
   assert property (psel && penable && paddr == ADDR_CRIT_LOC |-> !pslverr)
      else $error("mapped access refused");
   a_read_upper:
   assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   c_override: cover property ($fell(overtempPin_n));
   c_release: cover property ($rose(overtempPin_n));
   c_floor: cover property (warm1);
   c_refused: cover property (pslverr);
endmodule // fthys_top_chk
bind fthys_top fthys_top_chk chk (.clk_sys, .reset_n, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tempRemote1,
   .tempLocal, .tempRemote2, .floorDuty1, .startTemp1, .fanDriveOut1,
   .fanDriveOut2, .fanDriveOut3, .overtempPin_n);
`default_nettype wire
